// File: include/dbg_id_pkg.sv
package dbg_id_pkg;
  // Coprocessor read selector fields
  localparam logic [3:0] PRI_IDENTITY = 4'h0;
  localparam logic [3:0] PRI_ROM_POINTER = 4'h1;
  localparam logic [3:0] SEC_REG_ZERO = 4'h0;
  localparam logic [2:0] OPC_ZERO = 3'h0;
  // APB byte offset of the identity register on the debug slave port
  localparam logic [11:0] APB_IDENTITY_OFFSET = 12'h000;
  // Identity, main ID and ROM pointer field positions
  localparam int WATCHPOINT_LSB = 28;
  localparam int BREAKPOINT_LSB = 24;
  localparam int CTX_LSB = 20;
  localparam int ARCH_LSB = 16;
  localparam int VARIANT_LSB = 4;
  localparam int REVISION_LSB = 0;
  localparam int MAIN_ID_VARIANT_LSB = 20;
  localparam int MAIN_ID_REVISION_LSB = 0;
  localparam int ROM_BASE_LSB = 12;
  // Implemented resources, minus one
  localparam logic [3:0] WATCHPOINT_PAIRS_M1 = 4'h1;
  localparam logic [3:0] BREAKPOINT_PAIRS_M1 = 4'h2;
  localparam logic [3:0] CONTEXT_PAIRS_M1 = 4'h0;
  // Architecture code: arbitrary neutral value
  localparam logic [3:0] DEBUG_ARCH_CODE = 4'h9;
  localparam logic [1:0] ROM_VALID_YES = 2'h3;
  localparam logic [1:0] ROM_VALID_NO = 2'h0;
  localparam logic [31:0] READ_RESET = 32'h0000_0000;

  typedef struct packed {
    logic valid;
    logic [2:0] opc1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] opc2;
  } cp_read_s;
endpackage : dbg_id_pkg

// File: core/debug_identity_rom_pointer_regs.sv
`timescale 1ns/1ps
// What this block does
// [RL1] Identity register: 32-bit, read-only, any mode, reports version and resources.
// [RL2] Bits 31:28 hold watchpoint pair count minus one.
// [RL3] Bits 27:24 hold breakpoint pair count minus one.
// [RL4] Bits 23:20 hold context-comparing breakpoint pairs minus one.
// [RL5] Bits 19:16 hold fixed debug architecture version code.
// [RL6] Bits 7:4 equal main identification register bits 23:20.
// [RL7] Bits 3:0 equal main identification register bits 3:0.
// [RL8] Identity register also readable over the APB debug slave port.
// [RL9] Read with opcodes zero, c0, c0 returns identity register.
// [RL10] ROM pointer: 32-bit read-only, any mode, locates debug ROM.
// [RL11] Read with opcodes zero, c1, c0 returns ROM pointer.
// [RL12] ROM pointer bits 31:12 reflect the ROM base address strap.
// [RL13] ROM pointer bits 1:0 read 11 when valid strap set, else 00.
// [RL14] Integrator ties valid strap high whenever base address is valid.
// [RL15] Writes change nothing; reserved bits read zero.
module debug_identity_rom_pointer_regs
  import dbg_id_pkg::*;
(
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  // Integration inputs
  input wire logic [19:0] ROM_BASE_ADDRESS_STRAP_IN,
  input wire logic ROM_ADDRESS_VALID_STRAP_IN,
  input wire logic [31:0] MAIN_ID_IN,
  // Coprocessor read port
  input wire cp_read_s CP_READ_IN,
  output logic [31:0] CP_RDATA_OUT,
  output logic CP_RVALID_OUT,
  output logic CP_UNDEF_OUT,
  // APB debug slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [11:0] PADDR_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT
);

  logic [31:0] identity_word;
  logic [31:0] rom_pointer_word;
  logic sel_identity;
  logic sel_rom_pointer;
  logic apb_access;

  // Both words are pure functions of constants and inputs; no writable state exists
  always_comb
  begin
    identity_word = 32'h0000_0000;
    // [RL2] watchpoint pair field
    identity_word[WATCHPOINT_LSB +: 4] = WATCHPOINT_PAIRS_M1;
    // [RL3] breakpoint pair field
    identity_word[BREAKPOINT_LSB +: 4] = BREAKPOINT_PAIRS_M1;
    // [RL4] context compare field
    identity_word[CTX_LSB +: 4] = CONTEXT_PAIRS_M1;
    // [RL5] architecture version code
    identity_word[ARCH_LSB +: 4] = DEBUG_ARCH_CODE;
    // [RL6] variant mirrors main ID
    identity_word[VARIANT_LSB +: 4] = MAIN_ID_IN[MAIN_ID_VARIANT_LSB +: 4];
    // [RL7] revision mirrors main ID
    identity_word[REVISION_LSB +: 4] = MAIN_ID_IN[MAIN_ID_REVISION_LSB +: 4];
  end

  always_comb
  begin
    rom_pointer_word = 32'h0000_0000;
    // [RL12] base address from strap
    rom_pointer_word[ROM_BASE_LSB +: 20] = ROM_BASE_ADDRESS_STRAP_IN;
    // [RL13] valid bits from strap; [RL14] integrator keeps strap consistent
    rom_pointer_word[1:0] = ROM_ADDRESS_VALID_STRAP_IN ? ROM_VALID_YES : ROM_VALID_NO;
  end

  // [RL9] identity decode
  assign sel_identity = CP_READ_IN.opc1 == OPC_ZERO && CP_READ_IN.opc2 == OPC_ZERO &&
                        CP_READ_IN.crn == PRI_IDENTITY && CP_READ_IN.crm == SEC_REG_ZERO;
  // [RL11] ROM pointer decode
  assign sel_rom_pointer = CP_READ_IN.opc1 == OPC_ZERO && CP_READ_IN.opc2 == OPC_ZERO &&
                           CP_READ_IN.crn == PRI_ROM_POINTER && CP_READ_IN.crm == SEC_REG_ZERO;
  assign apb_access = PSEL_IN && !PENABLE_IN;

  // [RL1] [RL10] read-only in any mode, one-cycle answer
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      CP_RDATA_OUT <= READ_RESET;
      CP_RVALID_OUT <= 1'b0;
      CP_UNDEF_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      CP_RVALID_OUT <= CP_READ_IN.valid && (sel_identity || sel_rom_pointer);
      CP_UNDEF_OUT <= CP_READ_IN.valid && !(sel_identity || sel_rom_pointer);
      if (CP_READ_IN.valid && sel_identity)
        CP_RDATA_OUT <= identity_word;
      else if (CP_READ_IN.valid && sel_rom_pointer)
        CP_RDATA_OUT <= rom_pointer_word;
      else
        CP_RDATA_OUT <= READ_RESET;
    end
  end

  // [RL8] APB read of identity; [RL15] writes ignored, other offsets read zero
  always_ff @(posedge CLOCK_IN)
  begin
    if (SYS_RST_IN)
    begin
      PRDATA_OUT <= READ_RESET;
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      // Registered answer: PREADY rises in the access phase, so no wait is inserted twice
      PREADY_OUT <= apb_access;
      PSLVERR_OUT <= 1'b0;
      if (apb_access && !PWRITE_IN && PADDR_IN == APB_IDENTITY_OFFSET)
        PRDATA_OUT <= identity_word;
      else
        PRDATA_OUT <= READ_RESET;
    end
  end

  // Assertions
  // [RL9] identity read answered
  a_identity_answer: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL9]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RVALID_OUT && !CP_UNDEF_OUT)
    else $error("identity read not answered");
  // [RL2] watchpoint count field
  a_watchpoint_field: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL2]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[WATCHPOINT_LSB +: 4] == WATCHPOINT_PAIRS_M1)
    else $error("watchpoint field wrong");
  // [RL3] breakpoint count field
  a_breakpoint_field: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL3]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[BREAKPOINT_LSB +: 4] == BREAKPOINT_PAIRS_M1)
    else $error("breakpoint field wrong");
  // [RL4] context compare count
  a_context_field: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL4]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[CTX_LSB +: 4] == CONTEXT_PAIRS_M1)
    else $error("context field wrong");
  // [RL5] fixed architecture code
  a_arch_code_fixed: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL5]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[ARCH_LSB +: 4] == DEBUG_ARCH_CODE)
    else $error("architecture code wrong");
  // [RL6] variant mirrors main
  a_variant_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL6]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[7:4] == $past(MAIN_ID_IN[23:20]))
    else $error("variant mismatch");
  // [RL7] revision mirrors main
  a_revision_mirror: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL7]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[3:0] == $past(MAIN_ID_IN[3:0]))
    else $error("revision mismatch");
  // [RL15] identity reserved zero
  a_identity_reserved: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL15]
    CLK_EN_IN && CP_READ_IN.valid && sel_identity |=> CP_RDATA_OUT[15:8] == 8'h00)
    else $error("identity reserved bits set");
  // [RL11] ROM pointer answered
  a_rom_pointer_answer: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL11]
    CLK_EN_IN && CP_READ_IN.valid && sel_rom_pointer |=> CP_RVALID_OUT && !CP_UNDEF_OUT)
    else $error("rom pointer not answered");
  // [RL12] base address field
  a_rom_address_field: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL12]
    CLK_EN_IN && CP_READ_IN.valid && sel_rom_pointer |=> CP_RDATA_OUT[31:12] == $past(ROM_BASE_ADDRESS_STRAP_IN))
    else $error("rom pointer address wrong");
  // [RL13] valid bits follow strap
  a_rom_valid_bits: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL13]
    CLK_EN_IN && CP_READ_IN.valid && sel_rom_pointer |=> CP_RDATA_OUT[1:0] == ($past(ROM_ADDRESS_VALID_STRAP_IN) ? 2'h3 : 2'h0))
    else $error("rom valid bits wrong");
  // [RL15] pointer reserved zero
  a_rom_reserved_zero: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL15]
    CLK_EN_IN && CP_READ_IN.valid && sel_rom_pointer |=> CP_RDATA_OUT[11:2] == 10'h000)
    else $error("rom pointer reserved bits set");
  // [RL1] unmapped select refused
  a_undefined_select: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL1]
    CLK_EN_IN && CP_READ_IN.valid && !sel_identity && !sel_rom_pointer |=> CP_UNDEF_OUT && !CP_RVALID_OUT && CP_RDATA_OUT == 32'h0000_0000)
    else $error("bad select answered");
  // [RL1] answers last one cycle
  a_answer_one_cycle: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL1]
    CLK_EN_IN && !CP_READ_IN.valid |=> !CP_RVALID_OUT && !CP_UNDEF_OUT)
    else $error("answer without request");
  // [RL8] APB identity read
  a_apb_identity_read: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL8]
    CLK_EN_IN && apb_access && !PWRITE_IN && PADDR_IN == APB_IDENTITY_OFFSET |=> PREADY_OUT &&
    PRDATA_OUT[31:16] == {WATCHPOINT_PAIRS_M1, BREAKPOINT_PAIRS_M1, CONTEXT_PAIRS_M1, DEBUG_ARCH_CODE} &&
    PRDATA_OUT[15:0] == {8'h00, $past(MAIN_ID_IN[23:20]), $past(MAIN_ID_IN[3:0])})
    else $error("apb identity read wrong");
  // [RL15] APB write ignored
  a_apb_write_ignored: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL15]
    CLK_EN_IN && apb_access && PWRITE_IN |=> PREADY_OUT && !PSLVERR_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("apb write had effect");
  // [RL15] other offsets zero
  a_apb_other_offset: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL15]
    CLK_EN_IN && apb_access && !PWRITE_IN && PADDR_IN != APB_IDENTITY_OFFSET |=> PREADY_OUT && PRDATA_OUT == 32'h0000_0000)
    else $error("apb other offset not zero");
  // [RL8] ready only after setup
  a_apb_ready_pulse: assert property (@(posedge CLOCK_IN) disable iff (SYS_RST_IN) // [RL8]
    CLK_EN_IN && !apb_access |=> !PREADY_OUT && !PSLVERR_OUT)
    else $error("apb ready outside access");

  // Main scenarios
  c_identity_read: cover property (@(posedge CLOCK_IN) CLK_EN_IN && CP_READ_IN.valid && sel_identity);
  c_rom_read_valid: cover property (@(posedge CLOCK_IN) CLK_EN_IN && CP_READ_IN.valid && sel_rom_pointer &&
    ROM_ADDRESS_VALID_STRAP_IN);
  c_apb_read: cover property (@(posedge CLOCK_IN) CLK_EN_IN && apb_access && !PWRITE_IN);
  c_undefined_read: cover property (@(posedge CLOCK_IN) CLK_EN_IN && CP_READ_IN.valid && !sel_identity && !sel_rom_pointer);
  c_apb_write: cover property (@(posedge CLOCK_IN) CLK_EN_IN && apb_access && PWRITE_IN);

endmodule : debug_identity_rom_pointer_regs

// File: tb/apb_debugger_model.sv
`timescale 1ns/1ps
module apb_debugger_model (
  // Bus clock
  input wire logic clk_in,
  // Answer
  input wire logic pready_in,
  input wire logic [31:0] prdata_in,
  input wire logic pslverr_in,
  // Request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out
);
  initial
  begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'hfff;
  end
  // Held until ready; gap adds idle cycles first; ok low on timeout or error
  task automatic xfer(input int gap, input logic wr, input logic [11:0] addr, output logic [31:0] data,
    output logic ok);
    int n;
    n = 0;
    repeat (gap + 1) @(posedge clk_in);
    #1;
    psel_out = 1'b1;
    pwrite_out = wr;
    paddr_out = addr;
    @(posedge clk_in);
    #1;
    penable_out = 1'b1;
    do
    begin
      @(posedge clk_in);
      n++;
    end
    while (pready_in !== 1'b1 && n < 16);
    data = prdata_in;
    ok = (pready_in === 1'b1) && (pslverr_in === 1'b0);
    #1;
    psel_out = 1'b0;
    penable_out = 1'b0;
    // Released address never shows the last value
    paddr_out = ~addr;
  endtask : xfer
endmodule : apb_debugger_model

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import dbg_id_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [19:0] rom_base = 20'h00000;
  logic rom_ok = 1'b0;
  logic [31:0] main_id = 32'h0;
  cp_read_s cp = '0;
  logic [31:0] cp_rdata, prdata, got;
  logic cp_rvalid, cp_undef, psel, penable, pwrite, pready, pslverr, ok;
  logic clk_en = 1'b1;
  logic [11:0] paddr;
  int failures = 0;
  int compares = 0;
  always #25 clk = ~clk;
  debug_identity_rom_pointer_regs u_debug_identity_rom_pointer_regs (.CLOCK_IN(clk), .SYS_RST_IN(rst),
    .CLK_EN_IN(clk_en), .ROM_BASE_ADDRESS_STRAP_IN(rom_base), .ROM_ADDRESS_VALID_STRAP_IN(rom_ok),
    .MAIN_ID_IN(main_id), .CP_READ_IN(cp), .CP_RDATA_OUT(cp_rdata), .CP_RVALID_OUT(cp_rvalid),
    .CP_UNDEF_OUT(cp_undef), .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr));
  apb_debugger_model u_apb_debugger_model (.clk_in(clk), .pready_in(pready), .prdata_in(prdata),
    .pslverr_in(pslverr),
    .psel_out(psel), .penable_out(penable), .pwrite_out(pwrite), .paddr_out(paddr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic test_done();
    if (failures == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : test_done
  function automatic logic [31:0] id_exp(input logic [31:0] m);
    return {WATCHPOINT_PAIRS_M1, BREAKPOINT_PAIRS_M1, CONTEXT_PAIRS_M1, DEBUG_ARCH_CODE, 8'h00, m[23:20], m[3:0]};
  endfunction : id_exp
  // Request in its own cycle, answer one edge later, gone one edge after that
  task automatic cp_rd(input logic [3:0] rn, input logic [3:0] rm, input logic [2:0] o1, input logic [2:0] o2,
    input logic [31:0] exp, input logic undef);
    @(posedge clk);
    #1;
    chk({30'h0, cp_undef, cp_rvalid}, 32'h0);
    cp = '{1'b1, o1, rn, rm, o2};
    @(posedge clk);
    #1;
    cp = '0;
    chk(cp_rdata, exp);
    chk({30'h0, cp_undef, cp_rvalid}, {30'h0, undef, ~undef});
  endtask : cp_rd
  initial
  begin
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    rom_base = 20'hab5c3;
    rom_ok = 1'b1;
    main_id = 32'h6e9d_1a2c;
    chk(prdata | cp_rdata, 32'h0);
    chk({29'h0, pready, cp_rvalid, cp_undef}, 32'h0);
    cp_rd(4'h0, 4'h0, 3'h0, 3'h0, id_exp(main_id), 1'b0);
    cp_rd(4'h1, 4'h0, 3'h0, 3'h0, {rom_base, 12'h003}, 1'b0);
    rom_base = 20'h5a3c1;
    // Base no longer a valid address, so the strap drops
    rom_ok = 1'b0;
    cp_rd(4'h1, 4'h0, 3'h0, 3'h0, {rom_base, 12'h000}, 1'b0);
    main_id = 32'hbf6f_ff58;
    cp_rd(4'h0, 4'h0, 3'h0, 3'h0, id_exp(main_id), 1'b0);
    cp_rd(4'h2, 4'h0, 3'h0, 3'h0, 32'h0, 1'b1);
    cp_rd(4'h0, 4'h1, 3'h0, 3'h0, 32'h0, 1'b1);
    cp_rd(4'h1, 4'h0, 3'h1, 3'h0, 32'h0, 1'b1);
    cp_rd(4'h0, 4'h0, 3'h0, 3'h1, 32'h0, 1'b1);
    // Request held while the clock enable is low must wait
    @(posedge clk);
    #1;
    clk_en = 1'b0;
    cp = '{1'b1, 3'h0, 4'h1, 4'h0, 3'h0};
    @(posedge clk);
    #1;
    chk({30'h0, cp_undef, cp_rvalid}, 32'h0);
    clk_en = 1'b1;
    @(posedge clk);
    #1;
    cp = '0;
    chk({30'h0, cp_undef, cp_rvalid}, 32'h1);
    u_apb_debugger_model.xfer(0, 1'b0, APB_IDENTITY_OFFSET, got, ok);
    chk(got, id_exp(main_id));
    chk({31'h0, ok}, 32'h1);
    u_apb_debugger_model.xfer(3, 1'b1, APB_IDENTITY_OFFSET, got, ok);
    chk(got, 32'h0);
    chk({31'h0, ok}, 32'h1);
    u_apb_debugger_model.xfer(0, 1'b0, 12'h004, got, ok);
    chk(got, 32'h0);
    chk({31'h0, ok}, 32'h1);
    u_apb_debugger_model.xfer(0, 1'b0, APB_IDENTITY_OFFSET, got, ok);
    chk(got, id_exp(main_id));
    test_done();
  end
  initial
  begin
    #20000;
    failures++;
    test_done();
  end
endmodule : tb_top
